// >>> rtl/lpc_io_target_port.v
// LPC I/O target turning host I/O cycles into byte accesses on internal blocks
//
// Function
// - Every internal register reached from the host is one byte wide.
// - Only single-byte I/O reads and writes answered; other cycles leave bus alone.
// - No DMA or bus-master requests; DMA request output held inactive.
// - Read cycles drive SYNC three clocks after it is due, three clocks after the decode.
// - Wait SYNC held until ready, then ready SYNC 0000 driven.
// - One wait code per cycle, never switching between the two.
// - Data phase follows the ready SYNC on the very next clock.
// - All wait states use the long-wait code 0110.
// - First SYNC appears within 3 clocks of being due.
// - In reset device ignores frame, floats data, DMA request high.
// - Frame assertion starts a new cycle, abandoning any cycle in progress.
// - Active-low interface reset idles the cycle logic and floats the bus; bases and enables keep their values.
// - Each serial port decoded as eight bytes from its base.
// - Runtime window 0-7F and key window 0-1F from two bases.
// - Configuration port decoded as two bytes from its base.
// - Only serial IRQ and wake output exist; other sidebands absent.
// - All block bases, config included, relocatable after power-up.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_io_defs.vh"

module lpc_io_target_port (
	input  wire        clock,          // LPC bus clock
	input  wire        sys_rst,        // Asynchronous reset, active high
	input  wire        lpc_reset_n,    // Interface reset pin, active low
	input  wire [3:0]  lad_in,         // Address/data lines, sampled
	output reg  [3:0]  lad_out,        // Address/data lines, driven value
	output reg         lad_oe,         // Address/data lines drive enable
	input  wire        lframe_n,       // Frame pin, active low
	output wire        ldrq_n,         // DMA request, always inactive
	input  wire        wake_req,       // Wake event from internal logic
	output wire        wake_event_out_n,     // Open-drain wake output level
	output wire        wake_event_out_oe,    // Open-drain wake drive enable
	input  wire        serirq_in,      // Serial IRQ pin, sampled
	input  wire        serirq_drive,   // Serial IRQ drive from IRQ logic
	output wire        serirq_out,     // Serial IRQ driven value
	output wire        serirq_oe,      // Serial IRQ drive enable
	output wire        serirq_sample,  // Synchronised serial IRQ level
	input  wire [15:0] serial1_base,   // First serial port base
	input  wire [15:0] serial2_base,   // Second serial port base
	input  wire [15:0] runtime_base,   // Runtime window base
	input  wire [15:0] key_base,       // Security key window base
	input  wire [15:0] config_base,    // Configuration port base
	input  wire [4:0]  window_en,      // Window enables
	input  wire        base_load,      // Take new bases from config logic
	output reg         reg_req,        // Byte access request
	output reg         reg_write,      // Access is a write
	output reg  [2:0]  reg_block,      // Target block
	output reg  [6:0]  reg_offset,     // Offset in block
	output reg  [7:0]  reg_wdata,      // Write byte
	input  wire        reg_ack,        // Block finished the access
	input  wire [7:0]  reg_rdata       // Read byte, valid with reg_ack
);

	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_CTD   = 4'h1;
	localparam [3:0] ST_ADDR  = 4'h2;
	localparam [3:0] ST_WDATA = 4'h3;
	localparam [3:0] ST_TAR1  = 4'h4;
	localparam [3:0] ST_TAR2  = 4'h5;
	localparam [3:0] ST_SYNC  = 4'h6;
	localparam [3:0] ST_RDATA = 4'h7;
	localparam [3:0] ST_RTAR1 = 4'h8;
	localparam [3:0] ST_RTAR2 = 4'h9;
	localparam [3:0] ST_SKIP  = 4'hA;

	// Pin synchronisers, first stage read only by the second
	reg [3:0]  lad_s1_q, lad_q;
	reg        frame_s1_q, frame_n_q;
	reg        rst_s1_q, rst_n_q;
	reg        irq_s1_q, irq_q;

	reg [3:0]  state_q, state_d;
	reg        write_q, write_d;
	reg [15:0] addr_q, addr_d;
	reg [1:0]  cnt_q, cnt_d;
	reg [7:0]  data_q, data_d;
	reg        done_q, done_d;
	reg        lo_q, lo_d;
	reg [2:0]  blk_q, blk_d;
	reg [6:0]  off_q, off_d;
	reg        req_d, hit_q, hit_d;
	reg [3:0]  lad_out_d;
	reg        lad_oe_d;

	reg [15:0] s1_base_q, s2_base_q, rt_base_q, key_base_q, cfg_base_q;
	reg [4:0]  win_en_q;

	wire [2:0] dec_sel;
	wire [6:0] dec_off;
	wire       dec_hit;

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			lad_s1_q   <= 4'hF;
			lad_q      <= 4'hF;
			frame_s1_q <= 1'b1;
			frame_n_q  <= 1'b1;
			rst_s1_q   <= 1'b0;
			rst_n_q    <= 1'b0;
			irq_s1_q   <= 1'b1;
			irq_q      <= 1'b1;
		end else begin
			lad_s1_q   <= lad_in;
			lad_q      <= lad_s1_q;
			frame_s1_q <= lframe_n;
			frame_n_q  <= frame_s1_q;
			rst_s1_q   <= lpc_reset_n;
			rst_n_q    <= rst_s1_q;
			irq_s1_q   <= serirq_in;
			irq_q      <= irq_s1_q;
		end
	end

	// Bases relocatable, held until config logic reloads them
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1_base_q  <= `SERIAL1_BASE_RST;
			s2_base_q  <= `SERIAL2_BASE_RST;
			rt_base_q  <= `RUNTIME_BASE_RST;
			key_base_q <= `KEY_BASE_RST;
			cfg_base_q <= `CONFIG_BASE_RST;
			win_en_q   <= `WINDOW_EN_RST;
		end else if (base_load) begin
			s1_base_q  <= serial1_base;
			s2_base_q  <= serial2_base;
			rt_base_q  <= runtime_base;
			key_base_q <= key_base;
			cfg_base_q <= config_base;
			win_en_q   <= window_en;
		end
	end

	lpc_addr_decoder u_decoder (
		.addr         (addr_q),
		.serial1_base (s1_base_q),
		.serial2_base (s2_base_q),
		.runtime_base (rt_base_q),
		.key_base     (key_base_q),
		.config_base  (cfg_base_q),
		.window_en    (win_en_q),
		.block_sel    (dec_sel),
		.block_offset (dec_off),
		.hit          (dec_hit)
	);

	always @* begin
		state_d   = state_q;
		write_d   = write_q;
		addr_d    = addr_q;
		cnt_d     = cnt_q;
		data_d    = data_q;
		done_d    = done_q;
		lo_d      = lo_q;
		blk_d     = blk_q;
		off_d     = off_q;
		hit_d     = hit_q;
		req_d     = 1'b0;
		lad_out_d = `LPC_TAR_NIBBLE;
		lad_oe_d  = 1'b0;
		// Capture the block answer while waiting out the bus phases
		if (reg_req && reg_ack) begin
			done_d = 1'b1;
			if (!write_q)
				data_d = reg_rdata;
		end
		// Frame restarts decode from any state
		if (!frame_n_q) begin
			state_d = (lad_q == `LPC_START_TARGET) ? ST_CTD : ST_IDLE;
			done_d  = 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				state_d = ST_IDLE;
			end
			// Only I/O read and write cycle types go on
			ST_CTD: begin
				cnt_d = 2'h0;
				if (lad_q == `LPC_CTD_IO_READ) begin
					write_d = 1'b0;
					state_d = ST_ADDR;
				end else if (lad_q == `LPC_CTD_IO_WRITE) begin
					write_d = 1'b1;
					state_d = ST_ADDR;
				end else begin
					state_d = ST_SKIP;
				end
			end
			ST_ADDR: begin
				addr_d = {addr_q[11:0], lad_q};
				cnt_d  = cnt_q + 2'h1;
				if (cnt_q == `ADDR_LAST_NIBBLE) begin
					cnt_d   = 2'h0;
					state_d = write_q ? ST_WDATA : ST_TAR1;
				end
			end
			// Write byte arrives low nibble first
			ST_WDATA: begin
				data_d = {lad_q, data_q[7:4]};
				cnt_d  = cnt_q + 2'h1;
				if (cnt_q == `WDATA_LAST_NIBBLE) begin
					cnt_d   = 2'h0;
					state_d = ST_TAR1;
				end
			end
			ST_TAR1: begin
				// Decode settles here; a miss never drives the bus
				hit_d = dec_hit;
				blk_d = dec_sel;
				off_d = dec_off;
				state_d = dec_hit ? ST_TAR2 : ST_SKIP;
			end
			ST_TAR2: begin
				// One byte access per I/O cycle
				req_d   = 1'b1;
				done_d  = 1'b0;
				state_d = ST_SYNC;
			end
			ST_SYNC: begin
				// SYNC drive registered here; it reaches the bus three clocks after it is due
				lad_oe_d = 1'b1;
				req_d    = !done_q && !(reg_req && reg_ack);
				if (done_q) begin
					lad_out_d = `LPC_SYNC_READY;
					lo_d      = 1'b1;
					state_d   = write_q ? ST_RTAR1 : ST_RDATA;
				end else begin
					// Only the long-wait code is ever used
					lad_out_d = `LPC_SYNC_LONG_WAIT;
				end
			end
			ST_RDATA: begin
				lad_oe_d  = 1'b1;
				lad_out_d = lo_q ? data_q[3:0] : data_q[7:4];
				lo_d      = 1'b0;
				if (!lo_q)
					state_d = ST_RTAR1;
			end
			ST_RTAR1: begin
				// Turnaround: drive all ones for one clock, then release
				lad_oe_d  = 1'b1;
				lad_out_d = `LPC_TAR_NIBBLE;
				state_d   = ST_RTAR2;
			end
			ST_RTAR2: begin
				state_d = ST_IDLE;
			end
			ST_SKIP: begin
				state_d = ST_SKIP;
			end
			default: begin
				state_d = ST_IDLE;
			end
			endcase
		end
		// Outputs are registered, so the combinational term is one clock ahead
		if (state_q == ST_SYNC && state_d == ST_SYNC) begin
			lad_oe_d = 1'b1;
		end
	end

	// Interface reset holds the port idle and floating
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= ST_IDLE;
			write_q    <= 1'b0;
			addr_q     <= 16'h0000;
			cnt_q      <= 2'h0;
			data_q     <= 8'h00;
			done_q     <= 1'b0;
			lo_q       <= 1'b0;
			blk_q      <= `SEL_NONE;
			off_q      <= 7'h00;
			hit_q      <= 1'b0;
			lad_out    <= `LPC_TAR_NIBBLE;
			lad_oe     <= 1'b0;
			reg_req    <= 1'b0;
			reg_write  <= 1'b0;
			reg_block  <= `SEL_NONE;
			reg_offset <= 7'h00;
			reg_wdata  <= 8'h00;
		end else if (!rst_n_q) begin
			state_q    <= ST_IDLE;
			done_q     <= 1'b0;
			lad_out    <= `LPC_TAR_NIBBLE;
			lad_oe     <= 1'b0;
			reg_req    <= 1'b0;
		end else begin
			state_q    <= state_d;
			write_q    <= write_d;
			addr_q     <= addr_d;
			cnt_q      <= cnt_d;
			data_q     <= data_d;
			done_q     <= done_d;
			lo_q       <= lo_d;
			blk_q      <= blk_d;
			off_q      <= off_d;
			hit_q      <= hit_d;
			lad_out    <= lad_out_d;
			lad_oe     <= lad_oe_d;
			reg_req    <= req_d;
			reg_write  <= write_q;
			reg_block  <= blk_d;
			reg_offset <= off_d;
			reg_wdata  <= data_q;
		end
	end

	// No DMA support, request line parked inactive
	assign ldrq_n = 1'b1;

	// Only wake and serial IRQ sidebands exist
	assign wake_event_out_n  = 1'b0;
	assign wake_event_out_oe = wake_req;
	assign serirq_out        = 1'b0;
	assign serirq_oe         = serirq_drive;
	assign serirq_sample     = irq_q;

endmodule // lpc_io_target_port
`default_nettype wire

// >>> rtl/lpc_io_defs.vh
// Constants for the LPC I/O target port
`ifndef LPC_IO_DEFS_VH
`define LPC_IO_DEFS_VH

// Start field and cycle type/direction nibbles
`define LPC_START_TARGET   4'h0
`define LPC_CTD_IO_READ    4'h0
`define LPC_CTD_IO_WRITE   4'h2
// SYNC codes
`define LPC_SYNC_READY     4'h0
`define LPC_SYNC_LONG_WAIT 4'h6
`define LPC_SYNC_ERROR     4'hA
`define LPC_TAR_NIBBLE     4'hF
// Window sizes in bytes, minus one
`define SERIAL_SPAN        16'h0007
`define RUNTIME_SPAN       16'h007F
`define KEY_SPAN           16'h001F
`define CONFIG_SPAN        16'h0001
// Power-up base addresses
`define SERIAL1_BASE_RST   16'h03F8
`define SERIAL2_BASE_RST   16'h02F8
`define RUNTIME_BASE_RST   16'h0A00
`define KEY_BASE_RST       16'h0B00
`define CONFIG_BASE_RST    16'h002E
// Only the configuration window answers until the bases are loaded
`define WINDOW_EN_RST      5'h10
// Last nibble index of the address and write data fields
`define ADDR_LAST_NIBBLE   2'h3
`define WDATA_LAST_NIBBLE  2'h1
// Block select codes on the internal port
`define SEL_SERIAL1        3'h0
`define SEL_SERIAL2        3'h1
`define SEL_RUNTIME        3'h2
`define SEL_KEY            3'h3
`define SEL_CONFIG         3'h4
`define SEL_NONE           3'h7
// Latest cycle after SYNC is due that the first SYNC may appear
`define SYNC_LIMIT_CLOCKS  2'h3

`endif

// >>> rtl/lpc_addr_decoder.v
// Address decoder mapping an I/O address onto the enabled block windows
`timescale 1ns/1ps
`default_nettype none
`include "lpc_io_defs.vh"

module lpc_addr_decoder (
	input  wire [15:0] addr,          // I/O address of the cycle
	input  wire [15:0] serial1_base,  // First serial port base
	input  wire [15:0] serial2_base,  // Second serial port base
	input  wire [15:0] runtime_base,  // Runtime window base
	input  wire [15:0] key_base,      // Security key window base
	input  wire [15:0] config_base,   // Configuration port base
	input  wire [4:0]  window_en,     // Per-window enables
	output reg  [2:0]  block_sel,     // Selected block code
	output reg  [6:0]  block_offset,  // Offset inside the block
	output reg         hit            // Address lies in an enabled window
);

	function in_window;
		input [15:0] a;
		input [15:0] base;
		input [15:0] span;
		begin
			in_window = (a >= base) && ((a - base) <= span);
		end
	endfunction

	// Offset inside a window; no window is wider than seven address bits
	function [6:0] off_in;
		input [15:0] a;
		input [15:0] base;
		reg   [15:0] diff;
		begin
			diff   = a - base;
			off_in = diff[6:0];
		end
	endfunction

	always @* begin
		block_sel    = `SEL_NONE;
		block_offset = 7'h00;
		hit          = 1'b0;
		if (window_en[4] && in_window(addr, config_base, `CONFIG_SPAN)) begin
			block_sel    = `SEL_CONFIG;
			block_offset = off_in(addr, config_base);
			hit          = 1'b1;
		end else if (window_en[0] && in_window(addr, serial1_base, `SERIAL_SPAN)) begin
			block_sel    = `SEL_SERIAL1;
			block_offset = off_in(addr, serial1_base);
			hit          = 1'b1;
		end else if (window_en[1] && in_window(addr, serial2_base, `SERIAL_SPAN)) begin
			block_sel    = `SEL_SERIAL2;
			block_offset = off_in(addr, serial2_base);
			hit          = 1'b1;
		end else if (window_en[2] && in_window(addr, runtime_base, `RUNTIME_SPAN)) begin
			block_sel    = `SEL_RUNTIME;
			block_offset = off_in(addr, runtime_base);
			hit          = 1'b1;
		end else if (window_en[3] && in_window(addr, key_base, `KEY_SPAN)) begin
			block_sel    = `SEL_KEY;
			block_offset = off_in(addr, key_base);
			hit          = 1'b1;
		end
	end

endmodule // lpc_addr_decoder
`default_nettype wire

// >>> testbench/lpc_io_target_port_chk.sv
// Protocol checker for the LPC I/O target port
`timescale 1ns/1ps
`default_nettype none
module lpc_io_target_port_chk (
	input wire       clock,             // Bus clock
	input wire       sys_rst,           // Reset, active high
	input wire       lpc_reset_n,       // Interface reset
	input wire [3:0] lad_out,           // Driven nibble
	input wire       lad_oe,            // Drive enable
	input wire       ldrq_n,            // DMA request
	input wire       wake_req,          // Wake request
	input wire       wake_event_out_n,  // Wake level
	input wire       wake_event_out_oe, // Wake enable
	input wire       serirq_drive,      // IRQ drive request
	input wire       serirq_out,        // IRQ level
	input wire       serirq_oe,         // IRQ enable
	input wire       reg_write          // Access is a write
);
	logic prev_oe_q;
	logic in_wait_q;
	wire  wait_now  = lad_oe && lad_out == 4'h6 && (!prev_oe_q || in_wait_q);
	wire  ready_now = in_wait_q && lad_oe && lad_out == 4'h0;
	// Wait run is tracked so data nibbles equal to 6 are not taken for waits
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prev_oe_q <= 1'b0;
			in_wait_q <= 1'b0;
		end else begin
			prev_oe_q <= lad_oe;
			in_wait_q <= wait_now;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence release_s;
		lad_oe && lad_out == 4'hF ##1 !lad_oe;
	endsequence
	sequence read_tail_s;
		lad_oe ##1 lad_oe ##1 release_s;
	endsequence
	a_dma_idle: assert property (ldrq_n == 1'b1)
		else $error("DMA request went active");
	a_first_sync: assert property (disable iff (sys_rst || !lpc_reset_n)
		$rose(lad_oe) |-> lad_out == 4'h6 || lad_out == 4'h0) else $error("First SYNC code wrong");
	a_wait_steady: assert property (disable iff (sys_rst || !lpc_reset_n)
		wait_now |=> lad_oe && (lad_out == 4'h6 || lad_out == 4'h0)) else $error("Wait code changed");
	a_read_tail: assert property (disable iff (sys_rst || !lpc_reset_n)
		ready_now && !reg_write |=> read_tail_s) else $error("Read data phase wrong");
	a_write_tail: assert property (disable iff (sys_rst || !lpc_reset_n)
		ready_now && reg_write |=> release_s) else $error("Write turnaround wrong");
	a_reset_float: assert property (!lpc_reset_n [*3] |=> !lad_oe)
		else $error("Bus driven in reset");
	a_wake_od: assert property (wake_event_out_oe == wake_req && wake_event_out_n == 1'b0)
		else $error("Wake output not open drain");
	a_serirq_od: assert property (serirq_oe == serirq_drive && serirq_out == 1'b0)
		else $error("IRQ output not open drain");
endmodule // lpc_io_target_port_chk
bind lpc_io_target_port lpc_io_target_port_chk lpc_io_target_port_chk_i (.clock(clock), .sys_rst(sys_rst),
	.lpc_reset_n(lpc_reset_n), .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_n(ldrq_n), .wake_req(wake_req),
	.wake_event_out_n(wake_event_out_n), .wake_event_out_oe(wake_event_out_oe), .serirq_drive(serirq_drive),
	.serirq_out(serirq_out), .serirq_oe(serirq_oe), .reg_write(reg_write));
`default_nettype wire

// >>> testbench/lpc_host_model.sv
// Behavioural LPC host controller issuing I/O cycles
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model #(
	parameter int RESET_CYCLES = 25000 // 100 usec at 4 ns
) (
	input  wire logic       clock,       // Bus clock
	input  wire logic [3:0] lad,         // Resolved bus level
	input  wire logic       dev_oe,      // Target drive enable
	output logic            host_oe,     // Host drive enable
	output logic [3:0]      host_out,    // Host nibble
	output logic            lframe_n,    // Frame, active low
	output logic            lpc_reset_n  // Interface reset
);
	logic [7:0] rd;
	logic       answered;
	logic       code_bad;
	int         waits;
	int         lag;
	// clock stable, bus quiet in reset
	initial begin
		host_oe = 1'b0;
		host_out = 4'hF;
		lframe_n = 1'b1;
		lpc_reset_n = 1'b0;
		repeat (RESET_CYCLES) @(posedge clock);
		lpc_reset_n <= 1'b1;
	end
	task automatic put(input logic [3:0] n);
		@(posedge clock);
		host_out <= n;
		lframe_n <= 1'b1;
	endtask
	// Cut above zero stops after the address nibbles left, so the next frame aborts it
	task automatic io(input logic [3:0] ctd, input logic [15:0] addr, input logic [7:0] wd, input int cut);
		@(posedge clock);
		lframe_n <= 1'b0;
		host_oe <= 1'b1;
		host_out <= 4'h0;
		put(ctd);
		for (int i = 3; i >= cut; i--) put(addr[i*4 +: 4]);
		if (cut > 0) return;
		if (ctd[1]) begin
			put(wd[3:0]);
			put(wd[7:4]);
		end
		put(4'hF);
		@(posedge clock);
		host_oe <= 1'b0;
		answered = 1'b0;
		code_bad = 1'b0;
		waits = 0;
		lag = 0;
		rd = 8'h00;
		do begin
			@(negedge clock);
			lag++;
		end while (dev_oe !== 1'b1 && lag < 9);
		if (dev_oe !== 1'b1) return;
		answered = 1'b1;
		while (lad === 4'h6 && waits < 64) begin
			waits++;
			@(negedge clock);
		end
		if (lad !== 4'h0) code_bad = 1'b1;
		if (!ctd[1]) begin
			@(negedge clock);
			rd[3:0] = lad;
			@(negedge clock);
			rd[7:4] = lad;
		end
		@(negedge clock);
		if (lad !== 4'hF) code_bad = 1'b1;
		@(negedge clock);
		if (dev_oe !== 1'b0) code_bad = 1'b1;
	endtask
	task automatic bus_reset(input int n);
		@(posedge clock);
		lpc_reset_n <= 1'b0;
		repeat (n) @(posedge clock);
		lpc_reset_n <= 1'b1;
	endtask
endmodule // lpc_host_model
`default_nettype wire

// >>> testbench/test_lpc_io_target_port.sv
// Testbench for the LPC I/O target port
`timescale 1ns/1ps
`default_nettype none
`include "lpc_io_defs.vh"
module test_lpc_io_target_port;
	typedef struct {logic [3:0] ctd; logic [15:0] addr; logic [7:0] wd; logic hit; logic [2:0] blk; logic [6:0] off;} row_t;
	logic clock = 1'b0, sys_rst = 1'b1, lpc_reset_n, lframe_n, host_oe, base_load = 1'b0;
	logic [3:0] host_out, lad_out;
	logic lad_oe, ldrq_n, wake_req = 1'b0, wake_n, wake_oe, serirq_in = 1'b0, serirq_drive = 1'b0;
	logic serirq_out, serirq_oe, serirq_sample, reg_req, reg_write, reg_ack = 1'b0;
	logic [15:0] ser1 = `SERIAL1_BASE_RST, ser2 = `SERIAL2_BASE_RST, rt = `RUNTIME_BASE_RST;
	logic [15:0] key = `KEY_BASE_RST, cfg = `CONFIG_BASE_RST;
	logic [4:0] window_en = 5'h1F;
	logic [2:0] reg_block, got_blk;
	logic [6:0] reg_offset, got_off;
	logic [7:0] reg_wdata, got_wd, reg_rdata = 8'h00;
	logic got_write;
	int ack_delay = 0, ack_cnt = 0, req_count = 0, err_count = 0, total_checks = 0, n0, t;
	wire [3:0] lad = lad_oe ? lad_out : host_oe ? host_out : 4'hF;
	row_t rows [17] = '{
		'{4'h2, 16'h002E, 8'h3C, 1, `SEL_CONFIG, 7'h00}, '{4'h0, 16'h002F, 8'h00, 1, `SEL_CONFIG, 7'h01},
		'{4'h0, 16'h0030, 8'h00, 0, `SEL_NONE, 7'h00}, '{4'h0, 16'h03F8, 8'h00, 1, `SEL_SERIAL1, 7'h00},
		'{4'h2, 16'h03FF, 8'hC3, 1, `SEL_SERIAL1, 7'h07}, '{4'h0, 16'h0400, 8'h00, 0, `SEL_NONE, 7'h00},
		'{4'h0, 16'h02FF, 8'h00, 1, `SEL_SERIAL2, 7'h07}, '{4'h2, 16'h0A7F, 8'h81, 1, `SEL_RUNTIME, 7'h7F},
		'{4'h0, 16'h0A80, 8'h00, 0, `SEL_NONE, 7'h00}, '{4'h0, 16'h0B1F, 8'h00, 1, `SEL_KEY, 7'h1F},
		'{4'h0, 16'h0B20, 8'h00, 0, `SEL_NONE, 7'h00}, '{4'h4, 16'h002E, 8'h00, 0, `SEL_NONE, 7'h00},
		'{4'h6, 16'h03F8, 8'hFF, 0, `SEL_NONE, 7'h00}, '{4'h0, 16'h0107, 8'h00, 1, `SEL_SERIAL1, 7'h07},
		'{4'h0, 16'h03F8, 8'h00, 0, `SEL_NONE, 7'h00}, '{4'h2, 16'h004E, 8'h5A, 1, `SEL_CONFIG, 7'h00},
		'{4'h0, 16'h002E, 8'h00, 0, `SEL_NONE, 7'h00}};
	lpc_host_model host_i (.clock(clock), .lad(lad), .dev_oe(lad_oe), .host_oe(host_oe), .host_out(host_out),
		.lframe_n(lframe_n), .lpc_reset_n(lpc_reset_n));
	lpc_io_target_port lpc_io_target_port_i (.clock(clock), .sys_rst(sys_rst), .lpc_reset_n(lpc_reset_n),
		.lad_in(lad), .lad_out(lad_out), .lad_oe(lad_oe), .lframe_n(lframe_n), .ldrq_n(ldrq_n),
		.wake_req(wake_req), .wake_event_out_n(wake_n), .wake_event_out_oe(wake_oe), .serirq_in(serirq_in),
		.serirq_drive(serirq_drive), .serirq_out(serirq_out), .serirq_oe(serirq_oe),
		.serirq_sample(serirq_sample), .serial1_base(ser1), .serial2_base(ser2), .runtime_base(rt),
		.key_base(key), .config_base(cfg), .window_en(window_en), .base_load(base_load), .reg_req(reg_req),
		.reg_write(reg_write), .reg_block(reg_block), .reg_offset(reg_offset), .reg_wdata(reg_wdata),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata));
	initial forever #2 clock = ~clock;
	// Internal block stand-in; read byte is a known function of block and offset
	always @(posedge clock) begin
		reg_ack <= 1'b0;
		if (ack_cnt != 0) begin
			ack_cnt <= ack_cnt - 1;
			if (ack_cnt == 1) reg_ack <= 1'b1;
		end else if (reg_req === 1'b1 && reg_ack !== 1'b1) begin
			ack_cnt <= ack_delay + 1;
			req_count <= req_count + 1;
			got_write <= reg_write;
			got_blk <= reg_block;
			got_off <= reg_offset;
			got_wd <= reg_wdata;
			reg_rdata <= 8'h5A ^ {reg_block, reg_offset[4:0]};
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic run_row(input row_t r, input logic slow);
		n0 = req_count;
		host_i.io(r.ctd, r.addr, r.wd, 0);
		check("answered", host_i.answered, r.hit);
		check("requests", req_count - n0, r.hit);
		if (r.hit) begin
			check("block", got_blk, r.blk);
			check("offset", got_off, r.off);
			check("write", got_write, r.ctd[1]);
			check("sync", host_i.code_bad, 1'b0);
			check("lag", host_i.lag <= 5, 1'b1);
			if (r.ctd[1]) check("wdata", got_wd, r.wd);
			else check("rdata", host_i.rd, 8'h5A ^ {r.blk, r.off[4:0]});
			if (slow) check("waited", host_i.waits > 0, 1'b1);
		end
	endtask
	task automatic load_bases;
		@(posedge clock);
		base_load <= 1'b1;
		@(posedge clock);
		base_load <= 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		check("oe", lad_oe, 1'b0);
		check("lad", lad_out, 4'hF);
		check("req", reg_req, 1'b0);
		for (t = 0; t < 30000 && lpc_reset_n !== 1'b1; t++) @(posedge clock);
		// A reset that never lifts is a mismatch; the bounded cycles below then run out
		if (lpc_reset_n !== 1'b1) err_count++;
		repeat (4) @(posedge clock);
		run_row(rows[14], 1'b0);
		load_bases();
		for (int i = 0; i < 17; i++) begin
			if (i == 13) begin
				ser1 <= 16'h0100;
				cfg <= 16'h004E;
				load_bases();
			end
			@(posedge clock);
			ack_delay <= (i % 3) * 3;
			wake_req <= i[0];
			serirq_drive <= i[1];
			serirq_in <= i[0];
			run_row(rows[i], (i % 3) == 2);
		end
		// Abandoned cycle followed at once by a new frame
		host_i.io(4'h0, 16'h0100, 8'h00, 2);
		run_row('{4'h0, 16'h02F8, 8'h00, 1, `SEL_SERIAL2, 7'h00}, 1'b0);
		ack_delay <= 40;
		fork
			host_i.io(4'h0, 16'h0100, 8'h00, 0);
			begin
				repeat (14) @(posedge clock);
				host_i.bus_reset(6);
			end
		join
		repeat (60) @(posedge clock);
		ack_delay <= 0;
		run_row('{4'h0, 16'h0100, 8'h00, 1, `SEL_SERIAL1, 7'h00}, 1'b0);
		check("sample", serirq_sample, serirq_in);
		check("ldrq", ldrq_n, 1'b1);
		give_verdict();
	end
endmodule // test_lpc_io_target_port
`default_nettype wire
